// ==== dv/adc_backend_asserts.sv ====
// Port-level checks for the converter back end.
// Assumes it is bound into adc_backend and sees only its ports.
`timescale 1ns/1ps
module adc_backend_asserts (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        powerdown_pin,
	input wire logic        chip_select_low,
	input wire logic        data_a_oe,
	input wire logic        data_b_oe,
	input wire logic        data_clock_out_a_oe,
	input wire logic        data_clock_out_b_oe,
	input wire logic        serial_io_stabilizer_pin_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Pin passes a synchroniser, so a few cycles of settling are allowed
	a_pd_float:
	assert property (powerdown_pin [*6] |-> !data_a_oe && !data_b_oe && !data_clock_out_a_oe && !data_clock_out_b_oe)
		else $error("outputs driven while powered down");
	a_clk_oe_a:
	assert property (data_a_oe == data_clock_out_a_oe)
		else $error("channel A data and clock enables differ");
	a_clk_oe_b:
	assert property (data_b_oe == data_clock_out_b_oe)
		else $error("channel B data and clock enables differ");
	a_sdio_quiet:
	assert property (chip_select_low [*6] |-> !serial_io_stabilizer_pin_oe)
		else $error("serial line driven while deselected");
	a_rd_answer:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_unmapped:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h00C
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_rdata_upper:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_rd_release:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_wr_release:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule

bind adc_backend adc_backend_asserts adc_backend_asserts_inst (.*);

// ==== dv/adc_backend_tb_top.sv ====
// Self-checking bench for the converter back end.
// Assumes byte address = 4 * register index and a low-byte register field.
`timescale 1ns/1ps
module adc_backend_tb_top;
	localparam [11:0] A_SEL = 12'h014, A_STAB = 12'h024, A_TEST = 12'h034, A_BIST = 12'h038;
	localparam [11:0] A_MODE = 12'h050, A_PHASE = 12'h058, A_STAT = 12'h090, A_OE = 12'h404;
	logic        clk = 0, arst_n = 0, alt = 0, drv = 0, sa, sb;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, adc_a = 0, adc_b = 0;
	logic [11:0] data_a, data_b, cap_a, cap_b;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  r;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        adc_a_ovr = 0, adc_b_ovr = 0, adc_valid = 1, serial_clock_format_pin = 0;
	logic        chip_select_low = 0, powerdown_pin = 0, output_tristate_pin = 0;
	logic        serial_io_stabilizer_pin_out, serial_io_stabilizer_pin_oe, duty_cycle_stabilizer;
	logic        or_a, or_b, data_a_oe, data_b_oe, data_clock_out_a, data_clock_out_a_oe;
	logic        data_clock_out_b, data_clock_out_b_oe;
	logic [3:0]  tm [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
	logic [11:0] v0 [5] = '{12'h800, 12'hFFF, 12'h000, 12'hAAA, 12'hFFF};
	logic [11:0] v1 [5] = '{12'h800, 12'hFFF, 12'h000, 12'h555, 12'h000};
	int          error_cnt = 0, checks_done = 0;
	// No pull on the serial line: a released line shows the inverse of its last level
	wire         serial_io_stabilizer_pin_in = serial_io_stabilizer_pin_oe ? serial_io_stabilizer_pin_out : drv;

	adc_backend adc_backend_inst (.*);
	capture_model capture_model_inst (.data_a(data_a), .data_clock_out_a(data_clock_out_a), .cap_a(cap_a),
		.cap_b(cap_b));

	always #5 clk = ~clk;
	always @(posedge clk) adc_valid <= alt ? !adc_valid : 1'b1;

	task cmp(input string n, input [31:0] e, input [31:0] s);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	task wr(input [11:0] a, input [7:0] d, input [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp("bresp", er, s_axi_bresp);
	endtask

	task rd(input [11:0] a, input [7:0] e, input [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		cmp("rdata", {24'h00_0000, e}, s_axi_rdata);
		cmp("rresp", er, s_axi_rresp);
	endtask

	task put(input [11:0] x, input [11:0] y, input o);
		@(posedge clk);
		adc_a <= x;
		adc_b <= y;
		adc_a_ovr <= o;
		adc_b_ovr <= o;
	endtask

	task pins(input t, input p, input [3:0] e);
		@(posedge clk);
		output_tristate_pin <= t;
		powerdown_pin <= p;
		repeat (6) @(posedge clk);
		#1 cmp("oe", e, {data_a_oe, data_b_oe, data_clock_out_a_oe, data_clock_out_b_oe});
	endtask

	task spi(input [23:0] w);
		chip_select_low = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			drv = w[i];
			#62.5 serial_clock_format_pin = 1'b1;
			r = {r[6:0], serial_io_stabilizer_pin_in};
			#62.5 serial_clock_format_pin = 1'b0;
		end
		#62.5 chip_select_low = 1'b1;
		drv = ~drv;
	endtask

	function [11:0] fmt(input [11:0] x, input [1:0] f);
		fmt = f == 2'h1 ? x ^ 12'h800 : f == 2'h2 ? x ^ (x >> 1) : x;
	endfunction

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#200_000 error_cnt++;
		end_sim;
	end

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		chip_select_low <= 1'b1;
		rd(A_SEL, 8'h03, 2'h0);
		rd(A_MODE, 8'h00, 2'h0);
		rd(A_STAB, 8'h01, 2'h0);
		rd(12'h00C, 8'h00, 2'h2);
		wr(12'h00C, 8'h55, 2'h2);
		$display("test reset done");
		for (int f = 0; f < 3; f++) begin
			wr(A_MODE, f, 2'h0);
			put(12'h000, 12'hFFF, 1'b1);
			repeat (20) @(posedge clk);
			put(12'hFFF, 12'h000, 1'b0);
			repeat (16) @(posedge clk);
			#1 cmp("data_a", fmt(12'h000, f), data_a);
			cmp("or_a", 1, or_a);
			@(posedge clk);
			#1 cmp("data_a", fmt(12'hFFF, f), data_a);
			cmp("data_b", fmt(12'h000, f), data_b);
			cmp("or_b", 0, or_b);
		end
		wr(A_MODE, 8'h00, 2'h0);
		$display("test formats done");
		for (int i = 0; i < 5; i++) begin
			wr(A_TEST, tm[i], 2'h0);
			repeat (20) @(posedge clk);
			#1 cmp("pattern", 1, data_a === v0[i] || data_a === v1[i]);
		end
		wr(A_TEST, 8'h15, 2'h0);
		repeat (20) @(posedge clk);
		// Reseed held: the generator sits on its seed, low 12 bits of 0x5A5A
		#1 cmp("pn_reseed", 12'hA5A, data_a);
		wr(A_TEST, 8'h00, 2'h0);
		$display("test patterns done");
		// Data clock only toggles when samples leave a gap between them
		alt <= 1'b1;
		put(12'h456, 12'h789, 1'b0);
		repeat (30) @(posedge clk);
		cmp("cap_a", 12'h456, cap_a);
		wr(A_PHASE, 8'h80, 2'h0);
		put(12'h123, 12'h789, 1'b0);
		repeat (30) @(posedge clk);
		cmp("cap_a", 12'h123, cap_a);
		alt <= 1'b1;
		put(12'h111, 12'h222, 1'b0);
		wr(A_MODE, 8'h20, 2'h0);
		repeat (40) @(posedge clk);
		sa = 0;
		sb = 0;
		repeat (4) begin
			@(posedge clk);
			#1 sa |= data_a === 12'h111;
			sb |= data_a === 12'h222;
		end
		cmp("interleave", 2'h3, {sa, sb});
		wr(A_MODE, 8'h00, 2'h0);
		alt <= 1'b0;
		wr(A_SEL, 8'h02, 2'h0);
		wr(A_MODE, 8'h10, 2'h0);
		pins(0, 0, 4'hA);
		wr(A_MODE, 8'h00, 2'h0);
		wr(A_SEL, 8'h03, 2'h0);
		pins(1, 0, 4'hF);
		wr(A_OE, 8'h80, 2'h0);
		pins(1, 0, 4'h0);
		pins(0, 0, 4'hF);
		pins(0, 1, 4'h0);
		pins(0, 0, 4'hF);
		$display("test outputs done");
		wr(A_BIST, 8'h05, 2'h0);
		repeat (100) @(posedge clk);
		cmp("oe_bist", 1, data_a_oe);
		repeat (500) @(posedge clk);
		rd(A_STAT, 8'h02, 2'h0);
		wr(A_BIST, 8'h01, 2'h0);
		repeat (600) @(posedge clk);
		rd(A_STAT, 8'h02, 2'h0);
		$display("test selftest done");
		spi(24'h00_0900);
		repeat (10) @(posedge clk);
		cmp("stabilizer", 0, duty_cycle_stabilizer);
		rd(A_STAB, 8'h00, 2'h0);
		spi(24'h80_0500);
		cmp("spi_read", 8'h03, r);
		$display("test serial done");
		end_sim;
	end
endmodule

// ==== dv/capture_model.sv ====
// Far-side capture register, as receive logic in an FPGA would hold it.
// Assumes data and data clock come straight from the back end outputs.
`timescale 1ns/1ps
module capture_model (
	input  wire logic [11:0] data_a,
	input  wire logic        data_clock_out_a,
	output logic      [11:0] cap_a,
	output logic      [11:0] cap_b
);
	// Polarity inversion happens in the device, so the receiver never changes edge
	always @(posedge data_clock_out_a) cap_a <= data_a;
	always @(negedge data_clock_out_a) cap_b <= data_a;
endmodule

// ==== rtl/adc_backend.v ====
// Dual-channel 12-bit converter digital back end: test sources, sample
// pipeline, output formatting, output buses, self-test and register file.
// Assumes core samples arrive on clk with a valid strobe; pins are async.
`timescale 1ns/1ps
`include "adc_backend_map.vh"

module adc_backend #(
	parameter        PIPE_DEPTH     = `PIPE_DEPTH,
	parameter [15:0] BIST_SIGNATURE = 16'h0000
) (
	input  wire        clk,
	input  wire        arst_n,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [11:0] adc_a,
	input  wire        adc_a_ovr,
	input  wire [11:0] adc_b,
	input  wire        adc_b_ovr,
	input  wire        adc_valid,
	input  wire        serial_clock_format_pin,
	input  wire        serial_io_stabilizer_pin_in,
	output wire        serial_io_stabilizer_pin_out,
	output wire        serial_io_stabilizer_pin_oe,
	input  wire        chip_select_low,
	input  wire        powerdown_pin,
	input  wire        output_tristate_pin,
	output reg  [11:0] data_a,
	output reg         or_a,
	output reg         data_a_oe,
	output reg  [11:0] data_b,
	output reg         or_b,
	output reg         data_b_oe,
	output reg         data_clock_out_a,
	output reg         data_clock_out_a_oe,
	output reg         data_clock_out_b,
	output reg         data_clock_out_b_oe,
	output reg         duty_cycle_stabilizer
);
	localparam [10:0] BIST_RUN  = `BIST_CYCLES;
	localparam [10:0] BIST_EVAL = `BIST_CYCLES + PIPE_DEPTH;

	// Pin synchronisers: {tristate, powerdown, cs, sdio, sclk}
	reg  [4:0]  s1_r, s2_r;
	wire        sclk_s = s2_r[0];
	wire        sdio_s = s2_r[1];
	wire        csb_s  = s2_r[2];
	wire        pd_s   = s2_r[3];
	wire        oeb_s  = s2_r[4];

	reg  [1:0]  cap_cnt_r;
	reg         cap_done_r, strap_r;
	reg  [1:0]  chsel_r;
	reg         pwr_r, stab_r, il_r, lvds_r, inv_r, tri_en_r, pdis_a_r, pdis_b_r;
	reg  [5:0]  tm_r;
	reg  [1:0]  fmt_r, dly_r;
	reg         bist_act_r, bist_init_r, pass_r, done_r;
	reg  [10:0] bist_cnt_r;
	reg  [15:0] crc_r, pn_a_r, pn_b_r;
	reg         tog_r;
	reg         ph_r, dco_raw_r;
	reg  [12:0] pend_r;
	reg  [2:0]  dco_dly_r;
	reg         aw_hold_r, w_hold_r;
	reg  [12:0] aw_idx_r;
	reg  [7:0]  wdata_r;
	reg         wstrb0_r;

	wire [12:0] spi_addr;
	wire        spi_wr;
	wire [7:0]  spi_data;
	wire        axi_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid & ~spi_wr;
	wire        wr_en    = spi_wr | (axi_fire & wstrb0_r);
	wire [12:0] wr_idx   = spi_wr ? spi_addr : aw_idx_r;
	wire [7:0]  wr_dat   = spi_wr ? spi_data : wdata_r;
	wire        bist_go  = wr_en & (wr_idx == `IDX_BIST) & wr_dat[`B_BIST_EN];

	function [11:0] pattern;
		input [3:0]  mode;
		input [11:0] pn;
		input        tog;
		begin
			case (mode)
				`TM_MID:    pattern = 12'h800;
				`TM_PFS:    pattern = 12'hFFF;
				`TM_NFS:    pattern = 12'h000;
				`TM_CHECK:  pattern = tog ? 12'hAAA : 12'h555;
				`TM_PN:     pattern = pn;
				`TM_TOGGLE: pattern = tog ? 12'hFFF : 12'h000;
				default:    pattern = 12'h800;
			endcase
		end
	endfunction

	// Core codes arrive offset binary; other formats derive from them
	function [11:0] fmt_code;
		input [11:0] c;
		input [1:0]  sel;
		begin
			case (sel)
				`FMT_TWOS: fmt_code = {~c[11], c[10:0]};
				`FMT_GRAY: fmt_code = c ^ {1'b0, c[11:1]};
				default:   fmt_code = c;
			endcase
		end
	endfunction

	function [15:0] lfsr_step;
		input [15:0] s;
		begin
			lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		end
	endfunction

	function [15:0] crc_step;
		input [15:0] crc;
		input [23:0] d;
		integer k;
		reg [15:0] c;
		begin
			c = crc;
			for (k = 23; k >= 0; k = k - 1)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `CRC_POLY : 16'h0000);
			crc_step = c;
		end
	endfunction

	function [7:0] rd_mux;
		input [12:0] idx;
		begin
			case (idx)
				`IDX_CHAN_SEL:   rd_mux = {6'h00, chsel_r};
				`IDX_POWER:      rd_mux = {7'h00, pwr_r};
				`IDX_STAB:       rd_mux = {7'h00, stab_r};
				`IDX_TEST:       rd_mux = {2'h0, tm_r};
				`IDX_BIST:       rd_mux = {5'h00, bist_init_r, 1'b0, bist_act_r};
				`IDX_OUT_MODE:   rd_mux = {1'b0, lvds_r, il_r, chsel_r[0] ? pdis_a_r : pdis_b_r, 2'h0, fmt_r};
				`IDX_OUT_PHASE:  rd_mux = {inv_r, 7'h00};
				`IDX_DCO_DELAY:  rd_mux = {6'h00, dly_r};
				`IDX_BIST_STAT:  rd_mux = {6'h00, done_r, pass_r};
				`IDX_OUT_ENABLE: rd_mux = {tri_en_r, 7'h00};
				default:         rd_mux = 8'h00;
			endcase
		end
	endfunction

	function mapped;
		input [12:0] idx;
		begin
			case (idx)
				`IDX_CHAN_SEL, `IDX_POWER, `IDX_STAB, `IDX_TEST, `IDX_BIST, `IDX_OUT_MODE,
				`IDX_OUT_PHASE, `IDX_DCO_DELAY, `IDX_BIST_STAT, `IDX_OUT_ENABLE: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
		end else begin
			s1_r <= {output_tristate_pin, powerdown_pin, chip_select_low,
			         serial_io_stabilizer_pin_in, serial_clock_format_pin};
			s2_r <= s1_r;
		end
	end

	// Chip select high after reset selects strap mode and keeps the port dead
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_cnt_r  <= 2'h0;
			cap_done_r <= 1'b0;
			strap_r    <= 1'b0;
		end else if (!cap_done_r) begin
			cap_cnt_r <= cap_cnt_r + 2'h1;
			if (cap_cnt_r == `STRAP_WAIT) begin
				cap_done_r <= 1'b1;
				strap_r    <= csb_s;
			end
		end
	end

	serial_port u_serial (
		.clk        (clk),
		.arst_n     (arst_n),
		.sclk_s     (sclk_s),
		.sdio_s     (sdio_s),
		.csb_s      (csb_s | strap_r | ~cap_done_r),
		.rd_data    (rd_mux(spi_addr)),
		.addr_r     (spi_addr),
		.wr_r       (spi_wr),
		.wr_data_r  (spi_data),
		.sdio_out_r (serial_io_stabilizer_pin_out),
		.sdio_oe_r  (serial_io_stabilizer_pin_oe)
	);

	// Register file; a serial write and a bus write never land together
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chsel_r <= `RST_CHAN_SEL; pwr_r <= 1'b0; stab_r <= `RST_STAB; tm_r <= 6'h00;
			fmt_r <= `RST_FMT; il_r <= 1'b0; lvds_r <= 1'b0; inv_r <= 1'b0; dly_r <= 2'h0;
			tri_en_r <= 1'b0; pdis_a_r <= 1'b0; pdis_b_r <= 1'b0;
		end else if (wr_en) begin
			case (wr_idx)
				`IDX_CHAN_SEL:  chsel_r <= wr_dat[1:0];
				`IDX_POWER:     pwr_r <= wr_dat[`B_POWERDOWN_PIN];
				`IDX_STAB:      stab_r <= wr_dat[`B_STAB];
				`IDX_TEST:      tm_r <= wr_dat[5:0];
				`IDX_OUT_MODE: begin
					fmt_r  <= wr_dat[1:0];
					il_r   <= wr_dat[`B_INTERLEAVE];
					lvds_r <= wr_dat[`B_LVDS];
					if (chsel_r[`B_CHAN_A])
						pdis_a_r <= wr_dat[`B_PORT_DIS];
					if (chsel_r[`B_CHAN_B])
						pdis_b_r <= wr_dat[`B_PORT_DIS];
				end
				`IDX_OUT_PHASE:  inv_r <= wr_dat[`B_DCO_INV];
				`IDX_DCO_DELAY:  dly_r <= wr_dat[1:0];
				`IDX_OUT_ENABLE: tri_en_r <= wr_dat[`B_TRI_EN];
				default: ;
			endcase
		end
	end

	// Datapath source: self-test, then test pattern, then converter core
	wire        tm_on    = (tm_r[3:0] != `TM_OFF);
	wire        bist_run = bist_act_r & (bist_cnt_r < BIST_RUN);
	wire        stb      = bist_run | adc_valid;
	wire [11:0] src_a    = bist_run ? pn_a_r[11:0] : tm_on ? pattern(tm_r[3:0], pn_a_r[11:0], tog_r) : adc_a;
	wire [11:0] src_b    = bist_run ? pn_b_r[11:0] : tm_on ? pattern(tm_r[3:0], pn_b_r[11:0], tog_r) : adc_b;
	wire        src_or_a = ~bist_run & ~tm_on & adc_a_ovr;
	wire        src_or_b = ~bist_run & ~tm_on & adc_b_ovr;
	wire        pn_rst   = (bist_go & wr_dat[`B_BIST_INIT]) | tm_r[`B_PN_RST0] | tm_r[`B_PN_RST1];

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pn_a_r <= `PN_SEED_A;
			pn_b_r <= `PN_SEED_B;
			tog_r  <= 1'b0;
		end else begin
			if (stb)
				tog_r <= ~tog_r;
			if (pn_rst) begin
				pn_a_r <= `PN_SEED_A;
				pn_b_r <= `PN_SEED_B;
			end else if (stb & (bist_run | (tm_r[3:0] == `TM_PN))) begin
				pn_a_r <= lfsr_step(pn_a_r);
				pn_b_r <= lfsr_step(pn_b_r);
			end
		end
	end

	wire [26:0] q;
	wire        qv;
	// Flag and tag ride in the same word as the sample
	sample_pipe #(
		.W     (27),
		.DEPTH (PIPE_DEPTH)
	) u_pipe (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({bist_run, src_or_b, src_b, src_or_a, src_a}),
		.v      (stb),
		.q      (q),
		.qv     (qv)
	);

	wire [1:0]  fsel = strap_r ? {1'b0, sclk_s} : fmt_r;
	wire [11:0] fa   = fmt_code(q[11:0], fsel);
	wire [11:0] fb   = fmt_code(q[24:13], fsel);
	wire        drive_en = ~(pd_s | pwr_r) & ~(tri_en_r & oeb_s);
	wire [3:0]  dco_taps = {dco_dly_r, dco_raw_r};

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_a <= 12'h000; data_b <= 12'h000; or_a <= 1'b0; or_b <= 1'b0;
			pend_r <= 13'h0000; ph_r <= 1'b0; dco_raw_r <= 1'b1; dco_dly_r <= 3'h7;
			data_clock_out_a <= 1'b0; data_clock_out_b <= 1'b0;
			data_a_oe <= 1'b0; data_b_oe <= 1'b0;
			data_clock_out_a_oe <= 1'b0; data_clock_out_b_oe <= 1'b0;
			duty_cycle_stabilizer <= `RST_STAB;
		end else begin
			if (qv) begin
				data_a <= fa;
				or_a   <= q[12];
				if (il_r | lvds_r) begin
					pend_r    <= {q[25], fb};
					ph_r      <= 1'b1;
					dco_raw_r <= lvds_r;
				end else begin
					data_b    <= fb;
					or_b      <= q[25];
					ph_r      <= 1'b0;
					dco_raw_r <= 1'b0;
				end
			end else if (ph_r) begin
				data_a    <= pend_r[11:0];
				or_a      <= pend_r[12];
				ph_r      <= 1'b0;
				dco_raw_r <= ~lvds_r;
			end else if (!lvds_r) begin
				dco_raw_r <= 1'b1;
			end
			dco_dly_r        <= dco_taps[2:0];
			// Delay moves the clock later than the data for extra setup
			data_clock_out_a <= dco_taps[dly_r] ^ inv_r;
			data_clock_out_b <= dco_taps[dly_r] ^ inv_r;
			// Self-test does not gate these, so its sequence stays visible
			data_a_oe           <= drive_en & ~pdis_a_r;
			data_clock_out_a_oe <= drive_en & ~pdis_a_r;
			data_b_oe           <= drive_en & ~pdis_b_r;
			data_clock_out_b_oe <= drive_en & ~pdis_b_r;
			duty_cycle_stabilizer <= strap_r ? sdio_s : stab_r;
		end
	end

	// Self-test sequencing and signature
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bist_act_r <= 1'b0; bist_init_r <= 1'b0; bist_cnt_r <= 11'h000;
			pass_r <= 1'b0; done_r <= 1'b0; crc_r <= `CRC_INIT;
		end else begin
			if (bist_go) begin
				bist_act_r  <= 1'b1;
				bist_init_r <= wr_dat[`B_BIST_INIT];
				bist_cnt_r  <= 11'h000;
				pass_r      <= 1'b0;
				done_r      <= 1'b0;
				crc_r       <= `CRC_INIT;
			end else begin
				if (qv & q[26])
					crc_r <= crc_step(crc_r, {fb, fa});
				if (bist_act_r) begin
					bist_cnt_r <= bist_cnt_r + 11'h001;
					if (bist_cnt_r == BIST_EVAL) begin
						bist_act_r <= 1'b0;
						done_r     <= 1'b1;
						pass_r     <= (crc_r == BIST_SIGNATURE);
					end
				end
			end
		end
	end

	// AXI4-Lite slave: one write and one read in flight
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY; aw_hold_r <= 1'b0; w_hold_r <= 1'b0;
			aw_idx_r <= 13'h0000; wdata_r <= 8'h00; wstrb0_r <= 1'b0;
			s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0; s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awready & s_axi_awvalid) begin
				s_axi_awready <= 1'b0;
				aw_hold_r     <= 1'b1;
				aw_idx_r      <= {3'h0, s_axi_awaddr[11:2]};
			end
			if (s_axi_wready & s_axi_wvalid) begin
				s_axi_wready <= 1'b0;
				w_hold_r     <= 1'b1;
				wdata_r      <= s_axi_wdata[7:0];
				wstrb0_r     <= s_axi_wstrb[0];
			end
			if (axi_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_idx_r) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_r     <= 1'b0;
				w_hold_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arready & s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h00_0000, rd_mux({3'h0, s_axi_araddr[11:2]})};
				s_axi_rresp   <= mapped({3'h0, s_axi_araddr[11:2]}) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ==== rtl/adc_backend_map.vh ====
// Constants for the converter digital back end: register indices, field
// positions, reset values, encodings and timing counts.
// Assumes byte address = 4 * register index on the register bus.
`ifndef ADC_BACKEND_MAP_VH
`define ADC_BACKEND_MAP_VH

`define IDX_CHAN_SEL   13'h0005
`define IDX_POWER      13'h0008
`define IDX_STAB       13'h0009
`define IDX_TEST       13'h000D
`define IDX_BIST       13'h000E
`define IDX_OUT_MODE   13'h0014
`define IDX_OUT_PHASE  13'h0016
`define IDX_DCO_DELAY  13'h0017
`define IDX_BIST_STAT  13'h0024
`define IDX_OUT_ENABLE 13'h0101

`define B_CHAN_A       0
`define B_CHAN_B       1
`define B_POWERDOWN_PIN         0
`define B_STAB         0
`define B_PN_RST0      4
`define B_PN_RST1      5
`define B_BIST_EN      0
`define B_BIST_INIT    2
`define B_PORT_DIS     4
`define B_INTERLEAVE   5
`define B_LVDS         6
`define B_DCO_INV      7
`define B_TRI_EN       7

`define RST_CHAN_SEL   2'h3
`define RST_STAB       1'h1
`define RST_FMT        2'h0

`define FMT_OFFSET     2'h0
`define FMT_TWOS       2'h1
`define FMT_GRAY       2'h2

`define TM_OFF         4'h0
`define TM_MID         4'h1
`define TM_PFS         4'h2
`define TM_NFS         4'h3
`define TM_CHECK       4'h4
`define TM_PN          4'h5
`define TM_TOGGLE      4'h7

`define BIST_CYCLES    512
`define PIPE_DEPTH     16
`define STRAP_WAIT     2'h3
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'h1021
`define PN_SEED_A      16'h5A5A
`define PN_SEED_B      16'hA5A5

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== rtl/sample_pipe.v ====
// Fixed-length sample delay line with a travelling valid bit.
// Assumes samples on the same clock as the block; advances every cycle.
`timescale 1ns/1ps
module sample_pipe #(
	parameter W     = 27,
	parameter DEPTH = 16
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire [W-1:0] d,
	input  wire         v,
	output wire [W-1:0] q,
	output wire         qv
);
	reg [W-1:0]     st_r [0:DEPTH-1];
	reg [DEPTH-1:0] v_r;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : stage
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					st_r[i] <= {W{1'b0}};
					v_r[i]  <= 1'b0;
				end else if (i == 0) begin
					st_r[i] <= d;
					v_r[i]  <= v;
				end else begin
					st_r[i] <= st_r[i-1];
					v_r[i]  <= v_r[i-1];
				end
			end
		end
	endgenerate

	assign q  = st_r[DEPTH-1];
	assign qv = v_r[DEPTH-1];
endmodule

// ==== rtl/serial_port.v ====
// Serial control port: 16-bit instruction then 8-bit data words, MSB first.
// Assumes sclk, sdio and chip select already pass a two-stage synchroniser.
`timescale 1ns/1ps
module serial_port (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        sclk_s,
	input  wire        sdio_s,
	input  wire        csb_s,
	input  wire [7:0]  rd_data,
	output reg  [12:0] addr_r,
	output reg         wr_r,
	output reg  [7:0]  wr_data_r,
	output reg         sdio_out_r,
	output reg         sdio_oe_r
);
	reg        sclk_d_r;
	reg [4:0]  cnt_r;
	reg [15:0] sh_r;
	reg        rd_r;
	reg        load_r;
	reg        adv_r;
	reg [7:0]  out_sh_r;

	wire rise = sclk_s & ~sclk_d_r;
	wire fall = ~sclk_s & sclk_d_r;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d_r <= 1'b0; cnt_r <= 5'h00; sh_r <= 16'h0000; rd_r <= 1'b0;
			load_r <= 1'b0; adv_r <= 1'b0; out_sh_r <= 8'h00; addr_r <= 13'h0000;
			wr_r <= 1'b0; wr_data_r <= 8'h00; sdio_out_r <= 1'b0; sdio_oe_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			wr_r     <= 1'b0;
			load_r   <= 1'b0;
			adv_r    <= 1'b0;
			if (csb_s) begin
				// Frame ends whenever chip select rises
				cnt_r     <= 5'h00;
				rd_r      <= 1'b0;
				sdio_oe_r <= 1'b0;
			end else begin
				if (rise) begin
					sh_r <= {sh_r[14:0], sdio_s};
					if (cnt_r == 5'd15) begin
						// First instruction bit selects read or write
						rd_r   <= sh_r[14];
						addr_r <= {sh_r[11:0], sdio_s};
						load_r <= sh_r[14];
						cnt_r  <= 5'd16;
					end else if (cnt_r == 5'd23) begin
						wr_r      <= ~rd_r;
						wr_data_r <= {sh_r[6:0], sdio_s};
						adv_r     <= 1'b1;
						cnt_r     <= 5'd16;
					end else begin
						cnt_r <= cnt_r + 5'd1;
					end
				end
				// Streaming: next word goes to the next address
				if (adv_r) begin
					addr_r <= addr_r + 13'h0001;
					load_r <= rd_r;
				end
				if (load_r) begin
					out_sh_r   <= rd_data;
					sdio_out_r <= rd_data[7];
					sdio_oe_r  <= 1'b1;
				end else if (fall && rd_r && cnt_r > 5'd16) begin
					out_sh_r   <= {out_sh_r[6:0], 1'b0};
					sdio_out_r <= out_sh_r[6];
				end
			end
		end
	end
endmodule
